// ===== logic/aar_pkg.sv
// constants and types shared by the auto-negotiation ability register bank
// Behaviour
// - advertisement bit 15 is writable and advertises next page ability
// - advertisement bit 13 is writable, resets to zero, advertises remote fault
// - advertisement bit 11 is a writable asymmetric pause flag
// - advertisement bit 10 is a writable full-duplex pause flag
// - advertisement bit 9 (100BASE-T4) is read-only and always reads zero
// - advertisement bits 8..5 are writable duplex ability flags, each resetting to one
// - advertisement bits 4..0 are a writable selector resetting to 802.3 CSMA/CD
// - partner bit 15 is read-only, resets to zero, shows partner next page ability
// - partner bit 14 is read-only and shows the partner acknowledged our code word
// - partner bit 13 is read-only and shows partner signalled remote fault
// - partner bit 11 is read-only and shows partner asymmetric pause request
// - partner bit 10 is read-only and shows partner full-duplex pause support
// - partner bits 9..5 are read-only partner technology ability flags
// - partner bits 4..0 are read-only, reset to zero, partner selector field
// - an advertisement write before negotiation completes restarts negotiation
// - finishing negotiation never alters the advertisement register
package aar_pkg;
    // ---------------------------------------------------------------
    // register map and field layout
    // ---------------------------------------------------------------
    localparam logic [4:0]  ADV_OFFSET   = 5'h04;
    localparam logic [4:0]  LPA_OFFSET   = 5'h05;
    localparam int          BIT_NEXTPAGE = 15;
    localparam int          BIT_ACK      = 14;
    localparam int          BIT_RFAULT   = 13;
    localparam int          BIT_RSVD12   = 12;
    localparam int          BIT_T4       = 9;
    localparam logic [15:0] ADV_RESET    = 16'h01e1;
    localparam logic [15:0] LPA_RESET    = 16'h0000;
    // writable bits of the advertisement: 15,13,11,10,8..0
    localparam logic [15:0] ADV_WMASK    = 16'hadff;
    // bits of a received page kept in the partner register
    localparam logic [15:0] LPA_KMASK    = 16'hefff;

    // ---------------------------------------------------------------
    // management frame layout
    // ---------------------------------------------------------------
    localparam logic [1:0]  OP_READ      = 2'b10;
    localparam logic [1:0]  OP_WRITE     = 2'b01;
    localparam logic [3:0]  HDR_LAST     = 4'hb;
    localparam logic [3:0]  DATA_LAST    = 4'hf;
    localparam logic [3:0]  TA_LAST      = 4'h1;

    typedef enum {
        AAR_IDLE,
        AAR_START,
        AAR_HDR,
        AAR_TA,
        AAR_DATA
    } aar_state_e;

    // base page handed over by the negotiation engine
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } aar_page_s;
endpackage

// ===== logic/aar_ability_regs.sv
// auto-negotiation advertisement and link partner registers behind a management serial port
`timescale 1ns/10ps
module aar_ability_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              mdc,
    input  wire logic              mdioIn,
    output logic                   mdioOut,
    output logic                   mdioOe,
    input  wire logic              anComplete,
    input  wire aar_pkg::aar_page_s pageRx,
    output logic [15:0]            advWord,
    output logic [15:0]            lpaWord,
    output logic                   anRestart
);
    import aar_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0]  mdcSync_r;
    logic [2:0]  mdioSync_r;
    logic        mdcLvl_r;
    logic        mdcLvl_nxt;
    logic        mdioLvl_r;
    logic        mdioLvl_nxt;
    logic        mdcRise;
    logic        inBit;

    // a level counts only once the second and third stages agree, which filters single glitches
    always_comb begin
        mdcLvl_nxt  = (mdcSync_r[1] == mdcSync_r[2]) ? mdcSync_r[2] : mdcLvl_r;
        mdioLvl_nxt = (mdioSync_r[1] == mdioSync_r[2]) ? mdioSync_r[2] : mdioLvl_r;
        mdcRise     = mdcLvl_nxt & ~mdcLvl_r;
        inBit       = mdioLvl_nxt;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mdcSync_r  <= 3'h0;
            mdioSync_r <= 3'h7;
            mdcLvl_r   <= 1'b0;
            mdioLvl_r  <= 1'b1;
        end else begin
            mdcSync_r  <= {mdcSync_r[1:0], mdc};
            mdioSync_r <= {mdioSync_r[1:0], mdioIn};
            mdcLvl_r   <= mdcLvl_nxt;
            mdioLvl_r  <= mdioLvl_nxt;
        end
    end

    // ---------------------------------------------------------------
    // frame engine and registers
    // ---------------------------------------------------------------
    aar_state_e  st_r;
    aar_state_e  st_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic [15:0] rx_r;
    logic [15:0] rx_nxt;
    logic [15:0] tx_r;
    logic [15:0] tx_nxt;
    logic        rd_r;
    logic        rd_nxt;
    logic        wr_r;
    logic        wr_nxt;
    logic        selLpa_r;
    logic        selLpa_nxt;
    logic        oe_r;
    logic        oe_nxt;
    logic        out_r;
    logic        out_nxt;
    logic [15:0] adv_r;
    logic [15:0] adv_nxt;
    logic [15:0] lpa_r;
    logic [15:0] lpa_nxt;
    logic        rst_r;
    logic        rst_nxt;
    logic        wrStrobe;
    logic [11:0] hdr;
    logic [15:0] wrData;
    logic        hit;

    // one step per sampled clock edge; frames addressed elsewhere are tracked but never answered
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        rx_nxt     = rx_r;
        tx_nxt     = tx_r;
        rd_nxt     = rd_r;
        wr_nxt     = wr_r;
        selLpa_nxt = selLpa_r;
        oe_nxt     = oe_r;
        out_nxt    = out_r;
        adv_nxt    = adv_r;
        lpa_nxt    = lpa_r;
        rst_nxt    = 1'b0;
        wrStrobe   = 1'b0;
        hdr        = {rx_r[10:0], inBit};
        wrData     = {rx_r[14:0], inBit};
        hit        = (hdr[9:5] == PHY_ADDR) && ((hdr[4:0] == ADV_OFFSET) || (hdr[4:0] == LPA_OFFSET));
        if (mdcRise) begin
            case (st_r)
                AAR_IDLE: begin
                    // preamble ones keep us idle; the first zero begins the zero-one start pattern
                    if (!inBit) begin
                        st_nxt = AAR_START;
                    end
                end
                AAR_START: begin
                    st_nxt  = inBit ? AAR_HDR : AAR_IDLE;
                    cnt_nxt = 4'h0;
                end
                AAR_HDR: begin
                    rx_nxt  = {rx_r[14:0], inBit};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == HDR_LAST) begin
                        st_nxt     = AAR_TA;
                        cnt_nxt    = 4'h0;
                        rd_nxt     = hit && (hdr[11:10] == OP_READ);
                        wr_nxt     = hit && (hdr[11:10] == OP_WRITE) && (hdr[4:0] == ADV_OFFSET);
                        selLpa_nxt = (hdr[4:0] == LPA_OFFSET);
                    end
                end
                AAR_TA: begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'h0) begin
                        // drive the turnaround zero for reads
                        oe_nxt  = rd_r;
                        out_nxt = 1'b0;
                    end
                    if (cnt_r == TA_LAST) begin
                        st_nxt  = AAR_DATA;
                        cnt_nxt = 4'h0;
                        if (rd_r) begin
                            tx_nxt  = selLpa_r ? {lpa_r[14:0], 1'b0} : {adv_r[14:0], 1'b0};
                            out_nxt = selLpa_r ? lpa_r[15] : adv_r[15];
                        end
                    end
                end
                AAR_DATA: begin
                    rx_nxt  = {rx_r[14:0], inBit};
                    cnt_nxt = cnt_r + 4'h1;
                    if (rd_r) begin
                        out_nxt = tx_r[15];
                        tx_nxt  = {tx_r[14:0], 1'b0};
                    end
                    if (cnt_r == DATA_LAST) begin
                        st_nxt  = AAR_IDLE;
                        oe_nxt  = 1'b0;
                        out_nxt = 1'b0;
                        rd_nxt  = 1'b0;
                        wr_nxt  = 1'b0;
                        if (wr_r) begin
                            wrStrobe = 1'b1;
                            // read-only and reserved bits stay zero whatever is written
                            adv_nxt  = wrData & ADV_WMASK;
                            rst_nxt  = !anComplete;
                        end
                    end
                end
                default: begin
                    st_nxt = AAR_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
        // the partner register only follows received pages; the advertisement ignores completion
        if (pageRx.valid) begin
            lpa_nxt = pageRx.word & LPA_KMASK;
        end
    end

    // reset restores the documented defaults of both registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r     <= AAR_IDLE;
            cnt_r    <= 4'h0;
            rx_r     <= 16'h0000;
            tx_r     <= 16'h0000;
            rd_r     <= 1'b0;
            wr_r     <= 1'b0;
            selLpa_r <= 1'b0;
            oe_r     <= 1'b0;
            out_r    <= 1'b0;
            adv_r    <= ADV_RESET;
            lpa_r    <= LPA_RESET;
            rst_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            rx_r     <= rx_nxt;
            tx_r     <= tx_nxt;
            rd_r     <= rd_nxt;
            wr_r     <= wr_nxt;
            selLpa_r <= selLpa_nxt;
            oe_r     <= oe_nxt;
            out_r    <= out_nxt;
            adv_r    <= adv_nxt;
            lpa_r    <= lpa_nxt;
            rst_r    <= rst_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ---------------------------------------------------------------
    assign mdioOut   = out_r;
    assign mdioOe    = oe_r;
    assign advWord   = adv_r;
    assign lpaWord   = lpa_r;
    assign anRestart = rst_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence sAdvWrite;
        wrStrobe && !anComplete;
    endsequence

    sequence sRestartPulse;
        anRestart ##1 !anRestart;
    endsequence

    // second turnaround edge of a read aimed at us, where the top data bit is loaded
    sequence sReadLoad;
        mdcRise && rd_r && (st_r == AAR_TA) && (cnt_r == TA_LAST);
    endsequence

    AST_ADV_RSVD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        !adv_r[BIT_T4] && !adv_r[BIT_ACK] && !adv_r[BIT_RSVD12])
        else $error("advertisement read-only bit is set");

    AST_LPA_RSVD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        !lpaWord[BIT_RSVD12])
        else $error("partner reserved bit is set");

    AST_LPA_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        pageRx.valid |=> lpaWord == ($past(pageRx.word) & LPA_KMASK))
        else $error("partner register did not take the received page");

    AST_LPA_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !pageRx.valid |=> $stable(lpaWord))
        else $error("partner register changed without a page");

    AST_ADV_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !wrStrobe |=> $stable(advWord))
        else $error("advertisement changed without a write");

    AST_ADV_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe |=> (advWord == ($past(wrData) & ADV_WMASK)) && advWord[BIT_NEXTPAGE] == $past(wrData[15]))
        else $error("advertisement write not stored");

    AST_RESTART: assert property (@(posedge clk) disable iff (!resetn)
        sAdvWrite |=> sRestartPulse)
        else $error("no single restart pulse after early write");

    AST_NO_RESTART: assert property (@(posedge clk) disable iff (!resetn)
        anRestart |-> $past(wrStrobe) && !$past(anComplete))
        else $error("restart without an early advertisement write");

    AST_TA_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        $rose(mdioOe) |-> !mdioOut && $past(st_r == AAR_TA) && $past(rd_r))
        else $error("read turnaround did not drive zero");

    // the first bit on the wire must be the register top bit as it stood at the turnaround edge
    AST_RD_MSB: assert property (@(posedge clk) disable iff (!resetn)
        sReadLoad |=> mdioOut == $past(selLpa_r ? lpa_r[BIT_NEXTPAGE] : adv_r[BIT_NEXTPAGE]))
        else $error("first read bit is not the register top bit");

    // field by field, so a broken mask points at the field that lost its value
    AST_ADV_RFAULT: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe |=> advWord[BIT_RFAULT] == $past(wrData[BIT_RFAULT]))
        else $error("advertised remote fault not stored");

    AST_ADV_ABILITY: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe |=> (advWord[11:10] == $past(wrData[11:10])) && (advWord[8:5] == $past(wrData[8:5])))
        else $error("advertised pause or duplex flags not stored");

    AST_ADV_T4_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe && wrData[BIT_T4] |=> !advWord[BIT_T4])
        else $error("written one reached the unsupported technology bit");

    AST_ADV_SELECTOR: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe |=> advWord[4:0] == $past(wrData[4:0]))
        else $error("advertised selector not stored");

    AST_LPA_ACK: assert property (@(posedge clk) disable iff (!resetn)
        pageRx.valid |=> lpaWord[BIT_ACK] == $past(pageRx.word[BIT_ACK]))
        else $error("partner acknowledge not taken from the page");

    AST_LPA_RFAULT: assert property (@(posedge clk) disable iff (!resetn)
        pageRx.valid |=> lpaWord[BIT_RFAULT] == $past(pageRx.word[BIT_RFAULT]))
        else $error("partner remote fault not taken from the page");

    AST_LPA_SELECTOR: assert property (@(posedge clk) disable iff (!resetn)
        pageRx.valid |=> lpaWord[4:0] == $past(pageRx.word[4:0]))
        else $error("partner selector not taken from the page");

    // a write after completion must leave the engine alone
    AST_RESTART_LATE: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe && anComplete |=> !anRestart)
        else $error("restart after a write made once negotiation was complete");

    AST_LPA_PAGE_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        $changed(lpaWord) |-> $past(pageRx.valid))
        else $error("partner register moved with no received page");
endmodule

// ===== sim/aar_mgmt_host.sv
// management controller model that drives serial frames into the register bank
`timescale 1ns/10ps
module aar_mgmt_host (
    input  wire logic clk,
    input  wire logic mdioWire,
    output logic      mdc,
    output logic      hostOut,
    output logic      hostOe
);
    import aar_pkg::*;
    // --------------------------------------------------------------
    // idle state: mdc stands still low between frames
    // --------------------------------------------------------------
    initial begin
        mdc = 1'b0;
        hostOut = 1'b1;
        hostOe = 1'b0;
    end
    // one frame: short preamble, start, op, phy, reg, turnaround, data
    // mdc high for 8 clk and low for 9 clk keeps clear of the 300 ns minimum
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [35:0] frm;
        frm = {4'hf, 2'b01, op, phy, rg, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 35; i >= 0; i--) begin
            @(negedge clk);
            hostOe = (op != OP_READ) || (i > 17); // a read lets go from turnaround on
            hostOut = frm[i];
            repeat (8) @(negedge clk);
            if (i < 16) rd[i] = mdioWire; // taken just as mdc rises
            mdc = 1'b1;
            repeat (8) @(negedge clk);
            mdc = 1'b0;
        end
        @(negedge clk);
        hostOe = 1'b0;
    endtask
endmodule

// ===== sim/aar_ability_regs_tb.sv
// self-checking bench for the auto-negotiation ability register bank
`timescale 1ns/10ps
module aar_ability_regs_tb;
    import aar_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        anComplete = 1'b0;
    aar_page_s   pageRx = '0;
    logic        mdc, hostOut, hostOe, mdioOut, mdioOe, anRestart;
    logic [15:0] advWord, lpaWord, rdv;
    int          n_fail = 0;
    int          n_checks = 0;
    int          nRestart = 0;
    int          cycles = 0;
    // the wire has a pull-up, so a line nobody drives reads one
    wire         mdioWire = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);

    aar_ability_regs #(.PHY_ADDR(5'h01)) u_aar_ability_regs (.clk(clk), .resetn(resetn), .mdc(mdc),
        .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe), .anComplete(anComplete),
        .pageRx(pageRx), .advWord(advWord), .lpaWord(lpaWord), .anRestart(anRestart));
    aar_mgmt_host u_aar_mgmt_host (.clk(clk), .mdioWire(mdioWire), .mdc(mdc), .hostOut(hostOut),
        .hostOe(hostOe));

    // --------------------------------------------------------------
    // clock, restart pulse counter and hang guard
    // --------------------------------------------------------------
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (anRestart === 1'b1) nRestart++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] rg, input logic [15:0] v);
        u_aar_mgmt_host.xfer(OP_WRITE, 5'h01, rg, v, rdv);
    endtask
    task automatic rdr(input logic [4:0] rg);
        u_aar_mgmt_host.xfer(OP_READ, 5'h01, rg, 16'h0000, rdv);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        chk("advWord", advWord, 16'h01e1);
        chk("lpaWord", lpaWord, 16'h0000);
        rdr(ADV_OFFSET);
        chk("adv read", rdv, 16'h01e1);
        rdr(LPA_OFFSET);
        chk("lpa read", rdv, 16'h0000);
        $display("test reset done");
    endtask
    // all ones lands only on bits 15,13,11,10,8..0; each write restarts
    task automatic t_adv_write();
        int n0;
        n0 = nRestart;
        wr(ADV_OFFSET, 16'hffff);
        chk("advWord", advWord, 16'hadff);
        chk("restarts", 16'(nRestart - n0), 16'h0001);
        rdr(ADV_OFFSET);
        chk("adv read", rdv, 16'hadff);
        wr(ADV_OFFSET, 16'h0000);
        chk("advWord", advWord, 16'h0000);
        chk("restarts", 16'(nRestart - n0), 16'h0002);
        $display("test adv write done");
    endtask
    // after completion a write is kept but nothing restarts
    task automatic t_adv_done();
        int n0;
        anComplete = 1'b1;
        n0 = nRestart;
        wr(ADV_OFFSET, 16'h2c1f);
        chk("advWord", advWord, 16'h2c1f);
        chk("restarts", 16'(nRestart - n0), 16'h0000);
        anComplete = 1'b0;
        repeat (3) @(negedge clk);
        anComplete = 1'b1;
        repeat (3) @(negedge clk);
        chk("advWord", advWord, 16'h2c1f);
        $display("test adv done done");
    endtask
    task automatic t_page();
        pageRx = {1'b1, 16'hffff};
        @(negedge clk);
        pageRx.valid = 1'b0;
        @(negedge clk);
        chk("lpaWord", lpaWord, 16'hefff);
        chk("lpa ack", {15'h0, lpaWord[14]}, 16'h0001);
        chk("lpa rfault", {15'h0, lpaWord[13]}, 16'h0001);
        chk("lpa pause", {15'h0, lpaWord[10]}, 16'h0001);
        pageRx = {1'b1, 16'h5a5a};
        @(negedge clk);
        pageRx.valid = 1'b0;
        @(negedge clk);
        chk("lpaWord", lpaWord, 16'h4a5a);
        rdr(LPA_OFFSET);
        chk("lpa read", rdv, 16'h4a5a);
        wr(LPA_OFFSET, 16'h0000);
        chk("lpaWord", lpaWord, 16'h4a5a);
        chk("advWord", advWord, 16'h2c1f);
        $display("test page done");
    endtask
    // foreign phy address and a bad opcode are ignored; nothing drives the wire
    task automatic t_refused();
        u_aar_mgmt_host.xfer(OP_WRITE, 5'h02, ADV_OFFSET, 16'h0000, rdv);
        u_aar_mgmt_host.xfer(2'b11, 5'h01, ADV_OFFSET, 16'h0000, rdv);
        chk("advWord", advWord, 16'h2c1f);
        u_aar_mgmt_host.xfer(OP_READ, 5'h02, ADV_OFFSET, 16'h0000, rdv);
        chk("foreign read", rdv, 16'hffff);
        $display("test refused done");
    endtask
    task automatic t_reset_mid();
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk("lpaWord", lpaWord, 16'h0000);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        chk("advWord", advWord, 16'h01e1);
        rdr(LPA_OFFSET);
        chk("lpa read", rdv, 16'h0000);
        $display("test reset mid done");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_adv_write();
        t_adv_done();
        t_page();
        t_refused();
        t_reset_mid();
        results();
    end
endmodule
